// *** design/cscs_core.sv ***
// status word, saturation flags and the four context save pairs
// assumes the pipeline presents each event for exactly one core_clk cycle
// and that at most one instruction retires per cycle
`timescale 1ns/10ps
`default_nettype none

// Operation
// - irq or trap saves pc and status
// - nmi saves pc and status to nmi pair
// - debug occasions save into debug pair
// - table call saves into table-call pair
// - saved pc is the following instruction
// - debug pair readable only inside trap handler
// - illegal opcode raises the debug trap
// - pc save bit 0 always zero
// - pc save bits 31..26 zero
// - irq status save reserved bits zero
// - status saves upper bits zero
// - status write effective after instruction
// - reset loads status with irq block
// - nmi acknowledge sets nmi_active
// - exception sets exc_active and irq_block; exc_active alone still allows irqs
// - irq_block blocks irqs, even during write
// - clamp flag sticky, only saturation sets
// - arithmetic updates carry, wrap, sign, zero
// - positive overflow clamps to max positive
// - negative overflow clamps to max negative
// - in-range saturation passes raw result
// - registers reached by system register number
// - restarting instructions save their own pc
module cscs_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire cscs_pkg::cscs_evt_t evt,
  input wire logic [31:0] next_pc,
  input wire logic [31:0] cur_pc,
  input wire cscs_pkg::cscs_sreg_t sreg,
  input wire cscs_pkg::cscs_arith_t arith,
  output logic [31:0] program_status,
  output logic maskable_irq_ok,
  output logic debug_read_window,
  output logic [31:0] sysreg_rdata,
  output logic sysreg_rvalid,
  output logic sysreg_refused,
  output logic [31:0] sat_result
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // debug pair numbers, used by read gating and the assertions
  function automatic logic is_debug_num(input logic [4:0] n);
    is_debug_num = (n == cscs_pkg::SR_DBG_PC) || (n == cscs_pkg::SR_DBG_ST);
  endfunction

  // read mux; unmapped numbers read as zero
  function automatic logic [31:0] read_mux(input cscs_pkg::cscs_state_t st,
                                           input logic [4:0] n);
    unique case (n)
      cscs_pkg::SR_IRQ_PC: read_mux = st.irq_pc_save;
      cscs_pkg::SR_IRQ_ST: read_mux = st.irq_status_save;
      cscs_pkg::SR_NMI_PC: read_mux = st.nmi_pc_save;
      cscs_pkg::SR_NMI_ST: read_mux = st.nmi_status_save;
      cscs_pkg::SR_PSW: read_mux = st.program_status;
      cscs_pkg::SR_TC_PC: read_mux = st.table_call_pc_save;
      cscs_pkg::SR_TC_ST: read_mux = st.table_call_status_save;
      cscs_pkg::SR_DBG_PC: read_mux = st.debug_pc_save;
      cscs_pkg::SR_DBG_ST: read_mux = st.debug_status_save;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cscs_pkg::cscs_state_t s;       // every flip-flop of the block
  cscs_pkg::cscs_state_t next_s;  // its next value
  cscs_pkg::cscs_take_t take;     // which save pair this cycle
  logic [31:0] saved_pc;          // pc value bound for a save pair
  logic psw_write;                // status write this cycle
  logic pos_over;                 // saturation above positive max
  logic neg_over;                 // saturation below negative max
  logic enters_dbg_handler;       // entry to the trap handler

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  // one pair per cycle; nmi beats debug beats irq beats table call
  always_comb begin
    if (evt.nmi_ack) begin
      take = cscs_pkg::TAKE_NMI;
    end else if (evt.dbg_exc || evt.debug_trap_instr || evt.illegal_opcode) begin
      take = cscs_pkg::TAKE_DBG;
    end else if (evt.irq_ack || evt.soft_exc) begin
      take = cscs_pkg::TAKE_IRQ;
    end else if (evt.table_call_instr) begin
      take = cscs_pkg::TAKE_TC;
    end else begin
      take = cscs_pkg::TAKE_NONE;
    end
  end

  // restarting loads, divides and frame ops resume at their own address
  assign saved_pc = (evt.use_cur_pc && (evt.irq_ack || evt.nmi_ack)) ?
                    cur_pc : next_pc;
  assign enters_dbg_handler = evt.debug_trap_instr || evt.illegal_opcode;
  assign psw_write = sreg.load_sysreg_instr && (sreg.num == cscs_pkg::SR_PSW);
  assign pos_over = !arith.sat_wide[32] && arith.sat_wide[31];
  assign neg_over = arith.sat_wide[32] && !arith.sat_wide[31];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.refused = 1'b0;
    // software writes by register number; pc pairs drop bit 0 and top bits
    if (sreg.load_sysreg_instr) begin
      unique case (sreg.num)
        cscs_pkg::SR_IRQ_PC: next_s.irq_pc_save = sreg.wdata & cscs_pkg::PC_MASK;
        cscs_pkg::SR_IRQ_ST: next_s.irq_status_save = sreg.wdata & cscs_pkg::IRQ_ST_MASK;
        cscs_pkg::SR_NMI_PC: next_s.nmi_pc_save = sreg.wdata & cscs_pkg::PC_MASK;
        cscs_pkg::SR_NMI_ST: next_s.nmi_status_save = sreg.wdata & cscs_pkg::ST_MASK;
        cscs_pkg::SR_PSW: next_s.program_status = sreg.wdata & cscs_pkg::PSW_MASK;
        cscs_pkg::SR_TC_PC: next_s.table_call_pc_save = sreg.wdata & cscs_pkg::PC_MASK;
        cscs_pkg::SR_TC_ST: next_s.table_call_status_save = sreg.wdata & cscs_pkg::ST_MASK;
        cscs_pkg::SR_DBG_PC: next_s.debug_pc_save = sreg.wdata & cscs_pkg::PC_MASK;
        cscs_pkg::SR_DBG_ST: next_s.debug_status_save = sreg.wdata & cscs_pkg::ST_MASK;
        default: next_s.program_status = s.program_status;  // reserved: ignored
      endcase
    end
    // ordinary arithmetic never touches the clamp flag
    if (arith.arith_valid) begin
      next_s.program_status[cscs_pkg::BIT_CARRY] = arith.carry;
      next_s.program_status[cscs_pkg::BIT_WRAP] = arith.wrap;
      next_s.program_status[cscs_pkg::BIT_SIGN] = arith.sign;
      next_s.program_status[cscs_pkg::BIT_ZERO] = arith.zero;
    end
    // saturating ops clamp and only ever set the sticky flag
    if (arith.sat_valid) begin
      if (pos_over) begin
        next_s.sat_result = cscs_pkg::SAT_POS_MAX;
        next_s.program_status[cscs_pkg::BIT_CLAMP] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_WRAP] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_SIGN] = 1'b0;
        next_s.program_status[cscs_pkg::BIT_ZERO] = 1'b0;
      end else if (neg_over) begin
        next_s.sat_result = cscs_pkg::SAT_NEG_MAX;
        next_s.program_status[cscs_pkg::BIT_CLAMP] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_WRAP] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_SIGN] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_ZERO] = 1'b0;
      end else begin
        next_s.sat_result = arith.sat_wide[31:0];
        next_s.program_status[cscs_pkg::BIT_WRAP] = 1'b0;
        next_s.program_status[cscs_pkg::BIT_SIGN] = arith.sat_wide[31];
        next_s.program_status[cscs_pkg::BIT_ZERO] = (arith.sat_wide[31:0] == 32'h0000_0000);
      end
    end
    // entry: the pair catches the pre-entry status, same edge as the flags
    unique case (take)
      cscs_pkg::TAKE_NMI: begin
        next_s.nmi_pc_save = saved_pc & cscs_pkg::PC_MASK;
        next_s.nmi_status_save = s.program_status & cscs_pkg::ST_MASK;
        next_s.program_status[cscs_pkg::BIT_NMI_ACTIVE] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_IRQ_BLOCK] = 1'b1;
      end
      cscs_pkg::TAKE_DBG: begin
        next_s.debug_pc_save = saved_pc & cscs_pkg::PC_MASK;
        next_s.debug_status_save = s.program_status & cscs_pkg::ST_MASK;
        next_s.program_status[cscs_pkg::BIT_EXC_ACTIVE] = 1'b1;
        next_s.program_status[cscs_pkg::BIT_IRQ_BLOCK] = 1'b1;
      end
      cscs_pkg::TAKE_IRQ: begin
        next_s.irq_pc_save = saved_pc & cscs_pkg::PC_MASK;
        next_s.irq_status_save = s.program_status & cscs_pkg::IRQ_ST_MASK;
        next_s.program_status[cscs_pkg::BIT_IRQ_BLOCK] = 1'b1;
        if (evt.soft_exc && !evt.irq_ack) begin
          next_s.program_status[cscs_pkg::BIT_EXC_ACTIVE] = 1'b1;
        end
      end
      cscs_pkg::TAKE_TC: begin
        next_s.table_call_pc_save = saved_pc & cscs_pkg::PC_MASK;
        next_s.table_call_status_save = s.program_status & cscs_pkg::ST_MASK;
      end
      cscs_pkg::TAKE_NONE: begin
        next_s.rvalid = 1'b0;  // no save this cycle
      end
    endcase
    // handler window: entry sets, debug return clears, set wins a tie
    if (enters_dbg_handler) begin
      next_s.dbg_window = 1'b1;
    end else if (evt.debug_return_instr) begin
      next_s.dbg_window = 1'b0;
    end
    // reads answer next cycle; debug pair outside the window reads zero
    if (sreg.read_sysreg_instr) begin
      next_s.rvalid = 1'b1;
      if (is_debug_num(sreg.num) && !s.dbg_window) begin
        next_s.rdata = 32'h0000_0000;
        next_s.refused = 1'b1;
      end else begin
        next_s.rdata = read_mux(s, sreg.num);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // save pairs are cleared too, though software may not rely on it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.program_status <= cscs_pkg::PSW_RESET;
      s.irq_pc_save <= cscs_pkg::SAVE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a status write raising irq_block already blocks during its own cycle
  assign maskable_irq_ok = !s.program_status[cscs_pkg::BIT_IRQ_BLOCK] &&
                           !s.program_status[cscs_pkg::BIT_NMI_ACTIVE] &&
                           !(psw_write && sreg.wdata[cscs_pkg::BIT_IRQ_BLOCK]);
  assign program_status = s.program_status;
  assign debug_read_window = s.dbg_window;
  assign sysreg_rdata = s.rdata;
  assign sysreg_rvalid = s.rvalid;
  assign sysreg_refused = s.refused;
  assign sat_result = s.sat_result;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_irq_save;
    take == cscs_pkg::TAKE_IRQ |=>
      s.irq_pc_save == ($past(saved_pc) & cscs_pkg::PC_MASK) &&
      s.irq_status_save == ($past(s.program_status) & cscs_pkg::IRQ_ST_MASK);
  endproperty
  a_irq_save: assert property (p_irq_save) else $error("irq pair not saved");

  property p_nmi_save;
    evt.nmi_ack |=> s.nmi_pc_save == ($past(saved_pc) & cscs_pkg::PC_MASK) &&
      s.nmi_status_save == ($past(s.program_status) & cscs_pkg::ST_MASK);
  endproperty
  a_nmi_save: assert property (p_nmi_save) else $error("nmi pair not saved");

  property p_dbg_save;
    take == cscs_pkg::TAKE_DBG |=>
      s.debug_pc_save == ($past(saved_pc) & cscs_pkg::PC_MASK) &&
      s.debug_status_save == ($past(s.program_status) & cscs_pkg::ST_MASK);
  endproperty
  a_dbg_save: assert property (p_dbg_save) else $error("debug pair not saved");

  property p_tc_save;
    take == cscs_pkg::TAKE_TC |=>
      s.table_call_pc_save == ($past(next_pc) & cscs_pkg::PC_MASK) &&
      s.table_call_status_save == ($past(s.program_status) & cscs_pkg::ST_MASK);
  endproperty
  a_tc_save: assert property (p_tc_save) else $error("table call pair not saved");

  property p_restart_pc;
    evt.irq_ack && evt.use_cur_pc && !evt.nmi_ack && take == cscs_pkg::TAKE_IRQ |=>
      s.irq_pc_save == ($past(cur_pc) & cscs_pkg::PC_MASK);
  endproperty
  a_restart_pc: assert property (p_restart_pc) else $error("restart pc wrong");

  // every pc pair: bit 0 and the six top bits stay clear
  property p_pc_shape;
    ((s.irq_pc_save | s.nmi_pc_save | s.debug_pc_save | s.table_call_pc_save) &
     ~cscs_pkg::PC_MASK) == 32'h0000_0000;
  endproperty
  a_pc_shape: assert property (p_pc_shape) else $error("pc save shape bad");

  property p_irq_st_rsv;
    s.irq_status_save[31:12] == 20'h00000 && s.irq_status_save[10:8] == 3'h0;
  endproperty
  a_irq_st_rsv: assert property (p_irq_st_rsv) else $error("irq status reserved set");

  sequence s_dbg_closed;
    !s.dbg_window && sreg.read_sysreg_instr && is_debug_num(sreg.num);
  endsequence
  sequence s_refused_answer;
    ##1 sysreg_rvalid && sysreg_refused && sysreg_rdata == 32'h0000_0000;
  endsequence
  property p_dbg_gate;
    s_dbg_closed |-> s_refused_answer;
  endproperty
  a_dbg_gate: assert property (p_dbg_gate) else $error("debug read not refused");

  property p_illegal_trap;
    evt.illegal_opcode && !evt.nmi_ack |=> s.dbg_window &&
      s.program_status[cscs_pkg::BIT_EXC_ACTIVE];
  endproperty
  a_illegal_trap: assert property (p_illegal_trap) else $error("illegal op not trapped");

  property p_psw_write;
    psw_write && take == cscs_pkg::TAKE_NONE && !arith.arith_valid && !arith.sat_valid |=>
      s.program_status == ($past(sreg.wdata) & cscs_pkg::PSW_MASK);
  endproperty
  a_psw_write: assert property (p_psw_write) else $error("status write lost");

  property p_irq_block;
    (psw_write && sreg.wdata[cscs_pkg::BIT_IRQ_BLOCK]) ||
      s.program_status[cscs_pkg::BIT_IRQ_BLOCK] |-> !maskable_irq_ok;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("irq not blocked");

  property p_clamp_sticky;
    arith.arith_valid && !arith.sat_valid && !psw_write |=>
      $stable(s.program_status[cscs_pkg::BIT_CLAMP]);
  endproperty
  a_clamp_sticky: assert property (p_clamp_sticky) else $error("clamp flag moved");

  property p_sat_pos;
    arith.sat_valid && pos_over |=> sat_result == cscs_pkg::SAT_POS_MAX &&
      program_status[cscs_pkg::BIT_CLAMP] && program_status[cscs_pkg::BIT_WRAP];
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive clamp wrong");

  property p_sat_neg;
    arith.sat_valid && neg_over |=> sat_result == cscs_pkg::SAT_NEG_MAX &&
      program_status[cscs_pkg::BIT_CLAMP] && program_status[cscs_pkg::BIT_SIGN];
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative clamp wrong");

  property p_nmi_flag;
    evt.nmi_ack |=> program_status[cscs_pkg::BIT_NMI_ACTIVE] && !maskable_irq_ok;
  endproperty
  a_nmi_flag: assert property (p_nmi_flag) else $error("nmi_active not set");

endmodule

`default_nettype wire

// *** design/cscs_pkg.sv ***
// package for the cpu status word and context save block
// assumes a single core clock; all users refer to names as cscs_pkg::name
package cscs_pkg;

  // ----------------------------------------------------------------
  // system register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] SR_IRQ_PC = 5'h00;
  localparam logic [4:0] SR_IRQ_ST = 5'h01;
  localparam logic [4:0] SR_NMI_PC = 5'h02;
  localparam logic [4:0] SR_NMI_ST = 5'h03;
  localparam logic [4:0] SR_PSW = 5'h05;
  localparam logic [4:0] SR_TC_PC = 5'h10;
  localparam logic [4:0] SR_TC_ST = 5'h11;
  localparam logic [4:0] SR_DBG_PC = 5'h12;
  localparam logic [4:0] SR_DBG_ST = 5'h13;

  // ----------------------------------------------------------------
  // status word bit positions and values
  // ----------------------------------------------------------------
  localparam int unsigned BIT_NMI_ACTIVE = 7;
  localparam int unsigned BIT_EXC_ACTIVE = 6;
  localparam int unsigned BIT_IRQ_BLOCK = 5;
  localparam int unsigned BIT_CLAMP = 4;
  localparam int unsigned BIT_CARRY = 3;
  localparam int unsigned BIT_WRAP = 2;
  localparam int unsigned BIT_SIGN = 1;
  localparam int unsigned BIT_ZERO = 0;
  localparam logic [31:0] PSW_RESET = 32'h0000_0020;
  localparam logic [31:0] PSW_MASK = 32'h0000_00ff;
  localparam logic [31:0] PC_MASK = 32'h03ff_fffe;
  localparam logic [31:0] IRQ_ST_MASK = 32'h0000_08ff;
  localparam logic [31:0] ST_MASK = 32'h0000_0fff;
  localparam logic [31:0] SAVE_RESET = 32'h0000_0000;
  localparam logic [31:0] SAT_POS_MAX = 32'h7fff_ffff;
  localparam logic [31:0] SAT_NEG_MAX = 32'h8000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_ack;            // maskable interrupt acknowledged
    logic soft_exc;           // software trap instruction
    logic nmi_ack;            // non-maskable interrupt acknowledged
    logic dbg_exc;            // debug break or single-step stop
    logic debug_trap_instr;   // debug trap instruction
    logic illegal_opcode;     // illegal code detected
    logic table_call_instr;   // table call executes
    logic debug_return_instr; // debug return executes
    logic use_cur_pc;         // interrupted instr restarts
  } cscs_evt_t;

  typedef struct packed {
    logic load_sysreg_instr;
    logic read_sysreg_instr;
    logic [4:0] num;
    logic [31:0] wdata;
  } cscs_sreg_t;

  typedef struct packed {
    logic arith_valid;
    logic carry;
    logic wrap;
    logic sign;
    logic zero;
    logic sat_valid;
    logic [32:0] sat_wide;    // exact signed result, one bit wider
  } cscs_arith_t;

  typedef enum {TAKE_NONE, TAKE_NMI, TAKE_DBG, TAKE_IRQ, TAKE_TC} cscs_take_t;

  typedef struct packed {
    logic [31:0] program_status;
    logic [31:0] irq_pc_save;
    logic [31:0] irq_status_save;
    logic [31:0] nmi_pc_save;
    logic [31:0] nmi_status_save;
    logic [31:0] debug_pc_save;
    logic [31:0] debug_status_save;
    logic [31:0] table_call_pc_save;
    logic [31:0] table_call_status_save;
    logic dbg_window;
    logic [31:0] rdata;
    logic rvalid;
    logic refused;
    logic [31:0] sat_result;
  } cscs_state_t;

endpackage

// *** verif/tb.sv ***
// self-checking bench for the status word and context save block
// assumes cscs_core from design/ and cscs_pkg compiled first; one clock, async reset
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // stimulus and observation nets
  // ----------------------------------------------------------------
  logic core_clk = 1'b0; // 125 mhz core clock
  logic rst = 1'b1; // held high for six cycles
  cscs_pkg::cscs_evt_t evt = '0; // event pulses
  logic [31:0] next_pc = 32'h0; // following instruction address
  logic [31:0] cur_pc = 32'h0; // current instruction address
  cscs_pkg::cscs_sreg_t sreg = '0; // system register access
  cscs_pkg::cscs_arith_t arith = '0; // flag updates from the alu
  logic [31:0] program_status;
  logic maskable_irq_ok;
  logic debug_read_window;
  logic [31:0] sysreg_rdata;
  logic sysreg_rvalid;
  logic sysreg_refused;
  logic [31:0] sat_result;
  int err_count = 0; // mismatches
  int n_checks = 0; // comparisons made

  // clock: invert every half period
  always #4 core_clk = ~core_clk;

  cscs_core dut (
    .core_clk(core_clk),
    .rst(rst),
    .evt(evt),
    .next_pc(next_pc),
    .cur_pc(cur_pc),
    .sreg(sreg),
    .arith(arith),
    .program_status(program_status),
    .maskable_irq_ok(maskable_irq_ok),
    .debug_read_window(debug_read_window),
    .sysreg_rdata(sysreg_rdata),
    .sysreg_rvalid(sysreg_rvalid),
    .sysreg_refused(sysreg_refused),
    .sat_result(sat_result)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one comparison, four-state exact so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // load instruction: one-cycle pulse, taken at the following edge
  task automatic sr_write(input logic [4:0] num, input logic [31:0] d);
    @(posedge core_clk) sreg <= {1'b1, 1'b0, num, d};
    @(posedge core_clk) sreg <= '0;
    #1;
  endtask

  // read instruction: answer and refusal flag stand for one cycle after the take
  task automatic sr_read(input logic [4:0] num, input logic [31:0] exp, input logic ref_exp);
    @(posedge core_clk) sreg <= {1'b0, 1'b1, num, 32'h0};
    @(posedge core_clk) sreg <= '0;
    #1;
    chk("rvalid", 32'h1, {31'h0, sysreg_rvalid});
    chk("refused", {31'h0, ref_exp}, {31'h0, sysreg_refused});
    chk("rdata", exp, sysreg_rdata);
  endtask

  // one event pulse; pc inputs set with it
  task automatic fire(input logic [8:0] v, input logic [31:0] np, input logic [31:0] cp);
    @(posedge core_clk) begin
      evt <= cscs_pkg::cscs_evt_t'(v);
      next_pc <= np;
      cur_pc <= cp;
    end
    @(posedge core_clk) evt <= '0;
    #1;
  endtask

  // alu result pulse: {valid, carry, wrap, sign, zero}, saturation valid, wide result
  task automatic alu(input logic [4:0] f, input logic sv, input logic [32:0] w);
    @(posedge core_clk) arith <= {f, sv, w};
    @(posedge core_clk) arith <= '0;
    #1;
  endtask

  // verdict in one place, used by the sequence and the watchdog
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the sequence needs well under 300 cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("psw reset", 32'h20, program_status);
    chk("irq ok reset", 32'h0, {31'h0, maskable_irq_ok});
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    chk("irq ok open", 32'h1, {31'h0, maskable_irq_ok});
    // block bit must act while the write is still in flight
    @(posedge core_clk) sreg <= {2'b10, cscs_pkg::SR_PSW, 32'h20};
    #1;
    chk("irq ok during write", 32'h0, {31'h0, maskable_irq_ok});
    @(posedge core_clk) sreg <= '0;
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    // maskable irq: odd next address lands even
    fire(9'h100, 32'h0000_1235, 32'h0000_1230);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_1234, 1'b0);
    sr_read(cscs_pkg::SR_IRQ_ST, 32'h0, 1'b0);
    // software trap into the same pair, sets exception marker
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    fire(9'h080, 32'h0000_2000, 32'h0000_1ffc);
    chk("psw after trap", 32'h60, program_status);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_2000, 1'b0);
    // nmi during a restartable instruction saves its own address
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    fire(9'h041, 32'h0000_0104, 32'hfc00_0100);
    chk("psw after nmi", 32'ha0, program_status);
    sr_read(cscs_pkg::SR_NMI_PC, 32'h0000_0100, 1'b0);
    sr_read(cscs_pkg::SR_NMI_ST, 32'h0, 1'b0);
    // table call keeps the status word
    fire(9'h004, 32'h0000_0400, 32'h0000_03fe);
    sr_read(cscs_pkg::SR_TC_PC, 32'h0000_0400, 1'b0);
    sr_read(cscs_pkg::SR_TC_ST, 32'h0000_00a0, 1'b0);
    // debug pair hidden before the trap handler is entered
    sr_read(cscs_pkg::SR_DBG_PC, 32'h0, 1'b1);
    fire(9'h008, 32'h0000_0500, 32'h0000_04fc);
    chk("window open", 32'h1, {31'h0, debug_read_window});
    chk("psw after ilgl", 32'he0, program_status);
    sr_read(cscs_pkg::SR_DBG_PC, 32'h0000_0500, 1'b0);
    sr_read(cscs_pkg::SR_DBG_ST, 32'h0000_00a0, 1'b0);
    fire(9'h002, 32'h0, 32'h0);
    sr_read(cscs_pkg::SR_DBG_ST, 32'h0, 1'b1);
    // reserved bits of save registers read as zero
    sr_write(cscs_pkg::SR_IRQ_ST, 32'hffff_ffff);
    sr_read(cscs_pkg::SR_IRQ_ST, 32'h0000_08ff, 1'b0);
    sr_write(cscs_pkg::SR_NMI_ST, 32'hffff_ffff);
    sr_read(cscs_pkg::SR_NMI_ST, 32'h0000_0fff, 1'b0);
    sr_write(cscs_pkg::SR_TC_PC, 32'hffff_ffff);
    sr_read(cscs_pkg::SR_TC_PC, 32'h03ff_fffe, 1'b0);
    // flags: plain arithmetic, then each saturation outcome
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    alu(5'b11110, 1'b0, 33'h0);
    chk("psw arith", 32'h0e, program_status);
    alu(5'b00000, 1'b1, 33'h0_8000_0000);
    chk("sat pos", 32'h7fff_ffff, sat_result);
    chk("psw sat pos", 32'h1c, program_status);
    alu(5'b10000, 1'b0, 33'h0);
    chk("psw clamp kept", 32'h10, program_status);
    alu(5'b00000, 1'b1, 33'h1_ffff_fffe);
    chk("sat in range", 32'hffff_fffe, sat_result);
    chk("psw in range", 32'h12, program_status);
    alu(5'b00000, 1'b1, 33'h1_0000_0000);
    chk("sat neg", 32'h8000_0000, sat_result);
    chk("psw sat neg", 32'h16, program_status);
    sr_write(cscs_pkg::SR_PSW, 32'h0);
    chk("clamp cleared", 32'h0, program_status);
    // nested irq: only one pair, so software copies it out and back
    fire(9'h100, 32'h0000_3002, 32'h0000_3000);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_3002, 1'b0);
    sr_write(cscs_pkg::SR_PSW, 32'h8);
    chk("irq ok nested", 32'h1, {31'h0, maskable_irq_ok});
    fire(9'h101, 32'h0000_4004, 32'h0000_4000);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_4000, 1'b0);
    sr_read(cscs_pkg::SR_IRQ_ST, 32'h0000_0008, 1'b0);
    sr_write(cscs_pkg::SR_IRQ_PC, 32'h0000_3002);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_3002, 1'b0);
    // a break saves context but leaves the pair hidden; a debug trap instruction then opens it
    fire(9'h020, 32'h0000_0600, 32'h0000_05fc);
    chk("psw after break", 32'h68, program_status);
    chk("window after break", 32'h0, {31'h0, debug_read_window});
    sr_read(cscs_pkg::SR_DBG_PC, 32'h0, 1'b1);
    fire(9'h010, 32'h0000_0700, 32'h0000_06fc);
    sr_read(cscs_pkg::SR_DBG_PC, 32'h0000_0700, 1'b0);
    sr_read(cscs_pkg::SR_DBG_ST, 32'h0000_0068, 1'b0);
    // exception marker alone must not block maskable interrupts
    sr_write(cscs_pkg::SR_PSW, 32'h40);
    chk("irq ok in exc", 32'h1, {31'h0, maskable_irq_ok});
    // nmi and irq together: nmi wins, irq pair untouched
    fire(9'h140, 32'h0000_0800, 32'h0000_07fc);
    chk("psw nmi over irq", 32'he0, program_status);
    sr_read(cscs_pkg::SR_NMI_ST, 32'h0000_0040, 1'b0);
    sr_read(cscs_pkg::SR_IRQ_PC, 32'h0000_3002, 1'b0);
    // a second reset in mid-run restores the status word
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("psw reset again", 32'h20, program_status);
    chk("window reset", 32'h0, {31'h0, debug_read_window});
    chk("irq ok reset again", 32'h0, {31'h0, maskable_irq_ok});
    sr_read(cscs_pkg::SR_PSW, 32'h0000_0020, 1'b0);
    close_out();
  end
endmodule

`default_nettype wire
